// ==== hw/adc_control_registers.sv ====
module adc_control_registers (
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rstn_in,
  // register port
  input  wire logic [2:0]                 reg_addr_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire logic                       reg_write_in,
  input  wire logic                       reg_read_in,
  output logic      [7:0]                 reg_rdata_out,
  // trigger sources and internal RC oscillator
  input  wire adc_pkg::trigger_sources_t  trigger_sources_in,
  input  wire logic                       internal_rc_clock_in,
  // converter core
  input  wire logic                       comparator_in,
  output logic                            converter_power_out,
  output logic                            sample_switch_close_out,
  output logic      [9:0]                 trial_code_out,
  output logic                            bit_strobe_out,
  output adc_pkg::analog_select_t         analog_select_out,
  output adc_pkg::reference_select_t      reference_select_out,
  // events to the interrupt flags outside
  output logic                            conversion_done_flag_out,
  output logic                            timer_zero_flag_set_out,
  output logic                            timer_one_flag_set_out
);
  import adc_pkg::*;

  adc_state_t st;
  adc_state_t next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // half bit period in system clocks; zero marks the RC oscillator
  function automatic logic [5:0] half_len(input logic [2:0] sel);
    logic [5:0] len;
    len = 6'h00;
    if (sel == CLK_DIV2) begin
      len = HALF_DIV2;
    end else if (sel == CLK_DIV4) begin
      len = HALF_DIV4;
    end else if (sel == CLK_DIV8) begin
      len = HALF_DIV8;
    end else if (sel == CLK_DIV16) begin
      len = HALF_DIV16;
    end else if (sel == CLK_DIV32) begin
      len = HALF_DIV32;
    end else if (sel == CLK_DIV64) begin
      len = HALF_DIV64;
    end
    return len;
  endfunction

  // bits at and below idx are undecided: copy the last decided bit
  function automatic logic [9:0] fill_partial(input logic [9:0] sar,
                                              input logic [3:0] idx,
                                              input logic       any_done);
    logic [9:0] res;
    logic       last;
    res = sar;
    last = 1'b0;
    if (any_done && idx < RESULT_MSB) begin
      last = sar[idx + 4'h1];
    end
    for (int i = 0; i < 10; i++) begin
      if (i <= int'(idx) || !any_done) begin
        res[i] = last;
      end
    end
    return res;
  endfunction

  // split a ten-bit result into the high and low result bytes
  function automatic logic [15:0] justify(input logic [9:0] res, input logic right);
    logic [15:0] out;
    if (right) begin
      out = {6'h00, res[9:8], res[7:0]};
    end else begin
      out = {res[9:2], res[1:0], 6'h00};
    end
    return out;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic             wr_ctl0;
    logic             sw_clear_run;
    logic             sw_set_run;
    logic             trig_edge;
    trigger_sources_t edges;
    logic             half_tick;
    logic             rc_edge;
    logic [5:0]       hlen;
    logic             finish;
    logic             abort;
    logic [15:0]      packed_res;
    logic [9:0]       final_res;
    next_st = st;
    wr_ctl0 = reg_write_in && (reg_addr_in == OFS_CHANNEL_RUN);
    sw_set_run = wr_ctl0 && reg_wdata_in[POS_RUN];
    sw_clear_run = wr_ctl0 && !reg_wdata_in[POS_RUN];
    finish = 1'b0;
    abort = 1'b0;
    final_res = st.conversion_result;
    next_st.bit_strobe = 1'b0;
    next_st.done_pulse = 1'b0;
    packed_res = 16'h0000;
    half_tick = 1'b0;
    hlen = half_len(st.conversion_clock_select);
    rc_edge = st.rc_sync2 ^ st.rc_prev;
    // per-source edges come before the select, so reselecting fakes none
    edges = trigger_sources_in & ~st.trig_prev;
    trig_edge = 1'b0;

    // rc oscillator: two flops, then a third for edge detection
    next_st.rc_sync1 = internal_rc_clock_in;
    next_st.rc_sync2 = st.rc_sync1;
    next_st.rc_prev = st.rc_sync2;
    next_st.trig_prev = trigger_sources_in;
    case (st.auto_trigger_select)
      TRIG_CCP_ONE:  trig_edge = edges.capture_compare_unit_one;
      TRIG_CCP_TWO:  trig_edge = edges.capture_compare_unit_two;
      TRIG_TMR_ZERO: trig_edge = edges.timer_zero_wrap_event;
      TRIG_TMR_ONE:  trig_edge = edges.timer_one_wrap_event;
      TRIG_TMR_TWO:  trig_edge = edges.timer_two_period_match;
      default:       trig_edge = 1'b0;
    endcase
    // timer flags follow their event, selected or not
    next_st.timer_zero_flag_set = edges.timer_zero_wrap_event;
    next_st.timer_one_flag_set = edges.timer_one_wrap_event;

    // register writes
    if (reg_write_in) begin
      if (reg_addr_in == OFS_CHANNEL_RUN) begin
        next_st.analog_channel_select = reg_wdata_in[POS_CHAN_HI:POS_CHAN_LO];
        next_st.converter_enable = reg_wdata_in[POS_ENABLE];
      end else if (reg_addr_in == OFS_FORMAT_CLOCK) begin
        next_st.result_justify_select = reg_wdata_in[POS_JUSTIFY];
        next_st.conversion_clock_select = reg_wdata_in[POS_CLK_HI:POS_CLK_LO];
        next_st.negative_reference_select = reg_wdata_in[POS_NREF];
        next_st.positive_reference_select = reg_wdata_in[POS_PREF_HI:POS_PREF_LO];
      end else if (reg_addr_in == OFS_TRIGGER) begin
        next_st.auto_trigger_select = reg_wdata_in[POS_TRIG_HI:POS_TRIG_LO];
      end else if (reg_addr_in == OFS_RESULT_HIGH) begin
        next_st.result_high = reg_wdata_in;
      end else if (reg_addr_in == OFS_RESULT_LOW) begin
        next_st.result_low = reg_wdata_in;
      end
    end

    // half bit period tick from the divider or the rc oscillator
    if (hlen == 6'h00) begin
      half_tick = rc_edge;
    end else if (st.div_cnt >= hlen - 6'h01) begin
      half_tick = 1'b1;
    end
    if (st.state == CONV_IDLE || half_tick) begin
      next_st.div_cnt = 6'h00;
    end else begin
      next_st.div_cnt = st.div_cnt + 6'h01;
    end

    // conversion sequencer: 1.5 bit periods settle, then ten bits
    case (st.state)
      CONV_IDLE: begin
        next_st.half_cnt = 5'h00;
        next_st.bit_idx = RESULT_MSB;
        if (st.run && st.converter_enable) begin
          next_st.state = CONV_SETTLE;
          next_st.conversion_result = 10'h000;
        end
      end
      CONV_SETTLE: begin
        if (half_tick) begin
          next_st.half_cnt = st.half_cnt + 5'h01;
          if (st.half_cnt == {3'h0, SETTLE_HALVES} - 5'h01) begin
            next_st.state = CONV_BITS;
            next_st.half_cnt = 5'h00;
            next_st.conversion_result[RESULT_MSB] = 1'b1;
            next_st.bit_strobe = 1'b1;
          end
        end
      end
      CONV_BITS: begin
        if (half_tick) begin
          next_st.half_cnt = st.half_cnt + 5'h01;
          if (st.half_cnt[0]) begin
            // end of one bit period: keep or drop the trial bit
            next_st.conversion_result[st.bit_idx] = comparator_in;
            if (st.bit_idx == 4'h0) begin
              finish = 1'b1;
              final_res = st.conversion_result;
              final_res[0] = comparator_in;
            end else begin
              next_st.bit_idx = st.bit_idx - 4'h1;
              next_st.conversion_result[st.bit_idx - 4'h1] = 1'b1;
              next_st.bit_strobe = 1'b1;
            end
          end
        end
      end
      default: begin
        next_st.state = CONV_IDLE;
      end
    endcase

    // software abort keeps what is converted so far
    if (st.state != CONV_IDLE && sw_clear_run && !finish) begin
      abort = 1'b1;
      final_res = fill_partial(st.conversion_result, st.bit_idx,
                               st.state == CONV_BITS && st.bit_idx != RESULT_MSB);
    end

    if (finish || abort) begin
      next_st.bit_strobe = 1'b0;
      packed_res = justify(final_res, st.result_justify_select);
      next_st.result_high = packed_res[15:8];
      next_st.result_low = packed_res[7:0];
      next_st.state = CONV_IDLE;
      next_st.conversion_result = final_res;
      next_st.done_pulse = finish;
    end

    // disabling the converter stops any conversion
    if (!next_st.converter_enable) begin
      next_st.state = CONV_IDLE;
      next_st.bit_strobe = 1'b0;
    end

    // run flag: a set from software or trigger beats any clear
    if (sw_set_run || trig_edge) begin
      next_st.run = 1'b1;
    end else if (sw_clear_run || finish) begin
      next_st.run = 1'b0;
    end else if (!next_st.converter_enable) begin
      next_st.run = 1'b0;
    end

    // read data stands in the cycle after the read strobe
    next_st.read_data = 8'h00;
    if (reg_read_in) begin
      if (reg_addr_in == OFS_CHANNEL_RUN) begin
        next_st.read_data = {1'b0, st.analog_channel_select, st.run,
                             st.converter_enable};
      end else if (reg_addr_in == OFS_FORMAT_CLOCK) begin
        next_st.read_data = {st.result_justify_select, st.conversion_clock_select, 1'b0,
                             st.negative_reference_select,
                             st.positive_reference_select};
      end else if (reg_addr_in == OFS_TRIGGER) begin
        next_st.read_data = {st.auto_trigger_select, 4'h0};
      end else if (reg_addr_in == OFS_RESULT_HIGH) begin
        next_st.read_data = st.result_high;
      end else if (reg_addr_in == OFS_RESULT_LOW) begin
        next_st.read_data = st.result_low;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
      st.analog_channel_select <= RST_CONTROL[POS_CHAN_HI:POS_CHAN_LO];
      st.result_high <= RST_RESULT;
      st.result_low <= RST_RESULT;
      st.state <= CONV_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // channel routing; reserved codes leave every select low
  always_comb begin
    analog_select_out = '0;
    if (st.analog_channel_select <= CHAN_LAST_EXT) begin
      analog_select_out.ext_valid = 1'b1;
      analog_select_out.ext_index = st.analog_channel_select[3:0];
    end else if (st.analog_channel_select == CHAN_FVR_ONE) begin
      analog_select_out.fvr_one = 1'b1;
    end else if (st.analog_channel_select == CHAN_TEMP) begin
      analog_select_out.temp = 1'b1;
    end else if (st.analog_channel_select == CHAN_FVR_TWO) begin
      analog_select_out.fvr_two = 1'b1;
    end else begin
      analog_select_out = '0;
    end
  end

  // references; the reserved positive code selects nothing
  always_comb begin
    reference_select_out.pos_supply = st.positive_reference_select == PREF_SUPPLY;
    reference_select_out.pos_pin = st.positive_reference_select == PREF_PIN;
    reference_select_out.pos_fixed = st.positive_reference_select == PREF_FIXED;
    reference_select_out.neg_pin = st.negative_reference_select;
  end

  // switch closes only while enabled and idle; the capacitor is never discharged between runs
  assign sample_switch_close_out = st.converter_enable && (st.state == CONV_IDLE);
  assign converter_power_out = st.converter_enable;
  assign trial_code_out = st.conversion_result;
  assign bit_strobe_out = st.bit_strobe;
  assign reg_rdata_out = st.read_data;
  assign conversion_done_flag_out = st.done_pulse;
  assign timer_zero_flag_set_out = st.timer_zero_flag_set;
  assign timer_one_flag_set_out = st.timer_one_flag_set;

endmodule

// ==== hw/adc_pkg.sv ====
// What this block does
// - codes 0 to 11 route external inputs
// - codes 31, 29, 28 route internal sources
// - codes 12 to 27 and 30 connect nothing
// - writing run one starts a conversion
// - hardware clears run at completion
// - enable bit powers the converter
// - right justify zeroes six high bits
// - left justify zeroes six low bits
// - clock select picks divider or RC clock
// - negative reference ground or pin
// - positive reference supply, pin or fixed
// - four-bit field picks auto-trigger source
// - only rising trigger edges start conversions
// - timer wrap triggers also set timer flags
// - left format bit placement
// - right format bit placement
// - hold capacitor is never discharged
// - unimplemented bits read as zero
// - completion clears run, flags, loads results
// - abort loads partial result, fill last bit
// - trigger edge sets run in hardware
// - full conversion takes 11.5 bit periods
package adc_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_CHANNEL_RUN   = 3'h0;
  localparam logic [2:0] OFS_FORMAT_CLOCK  = 3'h1;
  localparam logic [2:0] OFS_TRIGGER       = 3'h2;
  localparam logic [2:0] OFS_RESULT_HIGH   = 3'h3;
  localparam logic [2:0] OFS_RESULT_LOW    = 3'h4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_ENABLE   = 0;
  localparam int POS_RUN      = 1;
  localparam int POS_CHAN_LO  = 2;
  localparam int POS_CHAN_HI  = 6;
  localparam int POS_PREF_LO  = 0;
  localparam int POS_PREF_HI  = 1;
  localparam int POS_NREF     = 2;
  localparam int POS_CLK_LO   = 4;
  localparam int POS_CLK_HI   = 6;
  localparam int POS_JUSTIFY  = 7;
  localparam int POS_TRIG_LO  = 4;
  localparam int POS_TRIG_HI  = 7;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RESULT  = 8'h00;

  // ----------------------------------------------------------------
  // channel, reference, clock and trigger codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CHAN_LAST_EXT = 5'h0B;
  localparam logic [4:0] CHAN_FVR_ONE  = 5'h1F;
  localparam logic [4:0] CHAN_TEMP     = 5'h1D;
  localparam logic [4:0] CHAN_FVR_TWO  = 5'h1C;
  localparam logic [1:0] PREF_SUPPLY   = 2'h0;
  localparam logic [1:0] PREF_PIN      = 2'h2;
  localparam logic [1:0] PREF_FIXED    = 2'h3;
  localparam logic [2:0] CLK_DIV2      = 3'h0;
  localparam logic [2:0] CLK_DIV4      = 3'h4;
  localparam logic [2:0] CLK_DIV8      = 3'h1;
  localparam logic [2:0] CLK_DIV16     = 3'h5;
  localparam logic [2:0] CLK_DIV32     = 3'h2;
  localparam logic [2:0] CLK_DIV64     = 3'h6;
  localparam logic [3:0] TRIG_NONE     = 4'h0;
  localparam logic [3:0] TRIG_CCP_ONE  = 4'h1;
  localparam logic [3:0] TRIG_CCP_TWO  = 4'h2;
  localparam logic [3:0] TRIG_TMR_ZERO = 4'h3;
  localparam logic [3:0] TRIG_TMR_ONE  = 4'h4;
  localparam logic [3:0] TRIG_TMR_TWO  = 4'h5;

  // ----------------------------------------------------------------
  // timing: half bit periods in system clocks per divider choice
  // ----------------------------------------------------------------
  localparam logic [5:0] HALF_DIV2      = 6'h01;
  localparam logic [5:0] HALF_DIV4      = 6'h02;
  localparam logic [5:0] HALF_DIV8      = 6'h04;
  localparam logic [5:0] HALF_DIV16     = 6'h08;
  localparam logic [5:0] HALF_DIV32     = 6'h10;
  localparam logic [5:0] HALF_DIV64     = 6'h20;
  localparam logic [1:0] SETTLE_HALVES  = 2'h3;  // 1.5 bit periods
  localparam logic [3:0] RESULT_MSB     = 4'h9;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CONV_IDLE   = 2'b00,
    CONV_SETTLE = 2'b01,
    CONV_BITS   = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic       ext_valid;
    logic [3:0] ext_index;
    logic       fvr_one;
    logic       temp;
    logic       fvr_two;
  } analog_select_t;

  typedef struct packed {
    logic pos_supply;
    logic pos_pin;
    logic pos_fixed;
    logic neg_pin;
  } reference_select_t;

  typedef struct packed {
    logic capture_compare_unit_one;
    logic capture_compare_unit_two;
    logic timer_zero_wrap_event;
    logic timer_one_wrap_event;
    logic timer_two_period_match;
  } trigger_sources_t;

  typedef struct packed {
    logic [4:0]       analog_channel_select;
    logic             run;
    logic             converter_enable;
    logic             result_justify_select;
    logic [2:0]       conversion_clock_select;
    logic             negative_reference_select;
    logic [1:0]       positive_reference_select;
    logic [3:0]       auto_trigger_select;
    logic [7:0]       result_high;
    logic [7:0]       result_low;
    logic [7:0]       read_data;
    conv_state_t      state;
    logic [5:0]       div_cnt;
    logic [4:0]       half_cnt;
    logic [3:0]       bit_idx;
    logic [9:0]       conversion_result;
    logic             bit_strobe;
    logic             done_pulse;
    trigger_sources_t trig_prev;
    logic             timer_zero_flag_set;
    logic             timer_one_flag_set;
    logic             rc_sync1;
    logic             rc_sync2;
    logic             rc_prev;
  } adc_state_t;

endpackage

// ==== tb/adc_control_registers_monitor.sv ====
module adc_control_registers_monitor (
  // clock and reset
  input wire logic                       clk_sys_in,
  input wire logic                       rstn_in,
  // register port
  input wire logic [2:0]                 reg_addr_in,
  input wire logic [7:0]                 reg_wdata_in,
  input wire logic                       reg_write_in,
  input wire logic                       reg_read_in,
  input wire logic [7:0]                 reg_rdata_out,
  // trigger inputs and block outputs
  input wire adc_pkg::trigger_sources_t  trigger_sources_in,
  input wire logic                       converter_power_out,
  input wire logic                       sample_switch_close_out,
  input wire logic                       bit_strobe_out,
  input wire adc_pkg::analog_select_t    analog_select_out,
  input wire adc_pkg::reference_select_t reference_select_out,
  input wire logic                       conversion_done_flag_out,
  input wire logic                       timer_zero_flag_set_out
);
  import adc_pkg::*;
  logic       ctl_write;
  logic [7:0] wd_q;
  // ----------------------------------------------------------------
  // decode and timing properties
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  // last write data, for the decode checks
  assign ctl_write = reg_write_in && reg_addr_in == 3'h0;
  always_ff @(posedge clk_sys_in) begin
    wd_q <= reg_wdata_in;
  end
  AST_ENABLE_ON: assert property (ctl_write && reg_wdata_in[0] |=> converter_power_out)
    else $error("converter not on");
  AST_ENABLE_OFF: assert property (ctl_write && !reg_wdata_in[0] |=>
    !converter_power_out && !sample_switch_close_out)
    else $error("disabled but active");
  AST_CHANNEL_EXTERNAL: assert property (ctl_write && reg_wdata_in[6:2] <= 5'h0B |=>
    analog_select_out.ext_valid && analog_select_out.ext_index == wd_q[5:2])
    else $error("external channel");
  AST_CHANNEL_INTERNAL: assert property (ctl_write |=>
    {analog_select_out.fvr_one, analog_select_out.temp, analog_select_out.fvr_two} ==
    {wd_q[6:2] == 5'h1F, wd_q[6:2] == 5'h1D, wd_q[6:2] == 5'h1C})
    else $error("internal source");
  AST_CHANNEL_RESERVED: assert property (ctl_write &&
    reg_wdata_in[6:2] inside {[5'h0C:5'h1B], 5'h1E} |=> analog_select_out == '0)
    else $error("reserved channel");
  AST_REFERENCE: assert property (reg_write_in && reg_addr_in == 3'h1 |=>
    reference_select_out == {wd_q[1:0] == 2'h0, wd_q[1:0] == 2'h2, wd_q[1:0] == 2'h3, wd_q[2]})
    else $error("reference");
  AST_TRIGGER_LOW_BITS: assert property (reg_read_in && reg_addr_in == 3'h2 |=>
    reg_rdata_out[3:0] == 4'h0)
    else $error("unused bits");
  AST_DONE_SINGLE: assert property (conversion_done_flag_out |=> !conversion_done_flag_out)
    else $error("long done pulse");
  AST_HOLD_DURING_BITS: assert property (bit_strobe_out |->
    converter_power_out && !sample_switch_close_out)
    else $error("bit while sampling");
  AST_TIMER_FLAG: assert property ($rose(trigger_sources_in.timer_zero_wrap_event) |=>
    timer_zero_flag_set_out)
    else $error("timer flag missing");
  AST_TIMER_FLAG_CAUSE: assert property (timer_zero_flag_set_out |->
    $past(trigger_sources_in.timer_zero_wrap_event) &&
    !$past(trigger_sources_in.timer_zero_wrap_event, 2))
    else $error("stray timer flag");
endmodule

bind adc_control_registers adc_control_registers_monitor MON (.*);

// ==== tb/adc_core_model.sv ====
module adc_core_model (
  // clock
  input  wire logic       clk_sys_in,
  // control block side
  input  wire logic [9:0] trial_code_in,
  input  wire logic       sample_close_in,
  input  wire logic       power_in,
  // level at the selected input
  input  wire logic [9:0] level_in,
  output logic            comparator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held;
  logic       last = 1'b0;
  // hold cap tracks only while the switch is closed, then keeps its charge
  always @(posedge clk_sys_in) begin
    if (sample_close_in) begin
      held <= level_in;
    end
    last <= comparator_out;
  end
  // unpowered: no usable decision, so it toggles
  assign comparator_out = power_in ? (trial_code_in <= held) : ~last;
endmodule

// ==== tb/adc_control_registers_tb.sv ====
module adc_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_pkg::*;
  // ----------------------------------------------------------------
  // ports and bench state
  // ----------------------------------------------------------------
  logic              clk_sys_in, rstn_in, reg_write_in, reg_read_in;
  logic              internal_rc_clock_in, comparator_in, converter_power_out;
  logic              sample_switch_close_out, bit_strobe_out, conversion_done_flag_out;
  logic              timer_zero_flag_set_out, timer_one_flag_set_out;
  logic [2:0]        reg_addr_in;
  logic [7:0]        reg_wdata_in, reg_rdata_out, d, hi;
  logic [9:0]        trial_code_out, level, e;
  trigger_sources_t  trigger_sources_in;
  analog_select_t    analog_select_out;
  reference_select_t reference_select_out;
  int                seed = 12762;
  int                fail_count, checks_done, cyc, first_t, done_t, strobes, dones, t, dn, t1s;
  int                half_tab[8] = '{1, 4, 16, 0, 2, 8, 32, 0};
  logic [23:0]       acc_tab[6] = '{24'h00FD7D, 24'h01FFF7, 24'h02FFF0, 24'h05FF00,
                                    24'h03A5A5, 24'h045A5A};
  adc_control_registers DUT (.*);
  adc_core_model CORE (
    .clk_sys_in, .trial_code_in(trial_code_out), .sample_close_in(sample_switch_close_out),
    .power_in(converter_power_out), .level_in(level), .comparator_out(comparator_in)
  );
  // system clock and a free-running RC oscillator
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    internal_rc_clock_in = 1'b0;
    forever #85.3 internal_rc_clock_in = ~internal_rc_clock_in;
  end
  // strobes, completions and timer one flags, seen one edge late
  always @(posedge clk_sys_in) begin
    cyc++;
    if (timer_one_flag_set_out === 1'b1) t1s++;
    if (bit_strobe_out === 1'b1) begin
      if (strobes == 0) first_t = cyc;
      strobes++;
    end
    if (conversion_done_flag_out === 1'b1) begin
      done_t = cyc;
      dones++;
    end
  end
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic j);
    return j ? {6'h00, r} : {r, 6'h00};
  endfunction
  function automatic logic [7:0] chsel(input logic [4:0] c);
    return {c <= 5'h0B, c <= 5'h0B ? c[3:0] : 4'h0, c == 5'h1F, c == 5'h1D, c == 5'h1C};
  endfunction
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask
  // read data stand one cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    @(negedge clk_sys_in);
    v = reg_rdata_out;
  endtask
  task automatic wait_dones(input int n);
    t = 0;
    while (dones < n && t < 3000) begin
      @(posedge clk_sys_in);
      t++;
    end
    check("completion", 16'h0001, 16'(t < 3000));
  endtask
  // enable, settle the input, start, then move the input
  task automatic start(input logic [2:0] k, input logic j, input logic [4:0] c);
    level <= 10'($random(seed));
    wr(3'h1, {j, k, 4'h0});
    wr(3'h0, {1'b0, c, 2'b01});
    repeat (8) @(posedge clk_sys_in);
    e = level;
    strobes = 0;
    dn = dones;
    wr(3'h0, {1'b0, c, 2'b11});
    @(posedge clk_sys_in); // switch opens one edge late
    level <= 10'($random(seed));
  endtask
  task automatic convert(input logic [2:0] k, input logic j, input logic [4:0] c);
    start(k, j, c);
    rd(3'h0, d);
    check("run while busy", 16'h0002, {8'h00, d & 8'h02});
    wait_dones(dn + 1);
    if (k[1:0] != 2'h3) begin
      check("strobe count", 16'h000A, 16'(strobes));
      check("bit time", 16'(20 * half_tab[k]), 16'(done_t - first_t));
    end
    rd(3'h3, hi);
    rd(3'h4, d);
    check("result", fmt(e, j), {hi, d});
    check("code", {6'h00, e}, {6'h00, trial_code_out});
    rd(3'h0, d);
    check("run cleared", {9'h000, c, 2'b01}, {8'h00, d});
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    end_sim();
  end
  initial begin
    rstn_in = 1'b0;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    reg_addr_in = 3'h0;
    reg_wdata_in = 8'h00;
    trigger_sources_in = '0;
    level = 10'h000;
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      check("reset", 16'h0000, {8'h00, d});
    end
    foreach (acc_tab[i]) begin
      wr(acc_tab[i][18:16], acc_tab[i][15:8]);
      rd(acc_tab[i][18:16], d);
      check("access", {8'h00, acc_tab[i][7:0]}, {8'h00, d});
    end
    for (int c = 0; c < 32; c++) begin
      wr(3'h0, {1'b0, 5'(c), 2'b00});
      @(negedge clk_sys_in);
      check("channel", {8'h00, chsel(5'(c))}, {8'h00, analog_select_out});
    end
    for (int r = 0; r < 8; r++) begin
      wr(3'h1, 8'(r));
      @(negedge clk_sys_in);
      check("reference", {12'h000, r[1:0] == 2'h0, r[1:0] == 2'h2, r[1:0] == 2'h3, r[2]},
        {12'h000, reference_select_out});
    end
    for (int k = 0; k < 8; k++) convert(3'(k), 1'($random(seed)), 5'($random(seed)));
    // abort a slow conversion once two bits are decided
    start(3'h6, 1'b0, 5'h00);
    t = 0;
    while (strobes < 3 && t < 1000) begin
      @(posedge clk_sys_in);
      t++;
    end
    repeat (10) @(posedge clk_sys_in);
    wr(3'h0, 8'h01);
    repeat (4) @(posedge clk_sys_in);
    rd(3'h3, hi);
    rd(3'h4, d);
    check("abort result", fmt({e[9:8], {8{e[8]}}}, 1'b0), {hi, d});
    check("abort done", 16'(dn), 16'(dones));
    // every trigger source: one other source ignored, a held level fires once
    wr(3'h1, 8'h00);
    for (int i = 1; i < 6; i++) begin
      wr(3'h2, {4'(i), 4'h0});
      dn = dones;
      trigger_sources_in <= 5'(1 << ((6 - i) % 5));
      repeat (40) @(posedge clk_sys_in);
      check("other", 16'(dn), 16'(dones));
      trigger_sources_in <= 5'(1 << (5 - i));
      wait_dones(dn + 1);
      repeat (60) @(posedge clk_sys_in);
      check("held", 16'(dn + 1), 16'(dones));
      trigger_sources_in <= '0;
    end
    check("timer one flag", 16'h0002, 16'(t1s));
    end_sim();
  end
endmodule
